// file: include/qqs_regs.svh
// Register offsets, reset values and field layouts of the QoS queue block
// What this block does
// - Four egress queues ranked highest, rank two, rank three and lowest.
// - Mode off or first-come-first-served sends packets strictly in arrival order.
// - Strict priority never serves a queue while a higher-ranked queue holds packets.
// - After reset the mode is weighted round robin with weights 8, 4, 2, 1.
// - In round robin a queue's weight sets packets sent before the next queue.
// - A tagged packet picks its queue by looking up its tag priority.
// - A programmable map sends each of eight priorities to any of four queues.
// - Reset map: 0-1 lowest, 2-3 rank three, 4-5 rank two, 6-7 highest.
// - Each port holds a static priority 0 to 7 given to untagged packets.
// - Untagged packets use the same priority-to-queue map as tagged ones.
`ifndef QQS_REGS_SVH
`define QQS_REGS_SVH
`define QQS_MODE_OFS 5'h00
`define QQS_WEIGHT_OFS 5'h04
`define QQS_MAP_OFS 5'h08
`define QQS_PORTPRI_OFS 5'h0C
`define QQS_STATUS_OFS 5'h10
`define QQS_MODE_RST 2'h3
`define QQS_WEIGHT_RST 32'h01020408
`define QQS_MAP_RST 16'h05AF
`define QQS_PORTPRI_RST 3'h0
`define QQS_MAP_FIELD_W 2
`define QQS_WEIGHT_FIELD_W 8
`define QQS_PORTPRI_FIELD_W 3
`define QQS_READ_WAIT 1
`endif

// file: include/qqs_pkg.sv
// Types shared by the QoS queue block
package qqs_pkg;
  typedef enum logic [1:0] {QQS_OFF, QQS_FCFS, QQS_STRICT, QQS_WRR} qqs_mode_e;
  typedef logic [1:0] qqs_queue_t;
endpackage : qqs_pkg

// file: verilog/qqs_desc_mem.sv
// Descriptor storage for the four queues, registered read
`timescale 1ns/100ps
`default_nettype none
module qqs_desc_mem #(
  parameter int WIDTH = 16,
  parameter int WORDS = 32,
  parameter int AW = $clog2(WORDS)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] store [WORDS];

  // Array has no reset so it maps onto block memory
  always_ff @(posedge clock)
  begin
    if (wrEn)
      store[wrAddr] <= wrData;
  end

  // Read data held until the next read
  always_ff @(posedge clock)
  begin
    if (rst)
      rdData <= '0;
    else if (rdEn)
      rdData <= store[rdAddr];
  end
endmodule : qqs_desc_mem
`default_nettype wire

// file: verilog/qqs_cfg_slave.sv
// Avalon-MM register slave for the QoS queue block
`timescale 1ns/100ps
`default_nettype none
`include "qqs_regs.svh"
module qqs_cfg_slave #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [31:0] status,
  output qqs_pkg::qqs_mode_e mode,
  output logic [31:0] weights,
  output logic [15:0] prioMap,
  output logic [3*NUM_PORTS-1:0] portPrio
);
  localparam int PPW = 3 * NUM_PORTS;
  logic ack;
  logic [31:0] curVal;
  logic [31:0] merged;

  // Byte-enable merge of write data into the current value
  function automatic logic [31:0] qqsMerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction : qqsMerge

  // One wait state on every access, so read data come from a flop
  assign waitrequest = (read | write) & ~ack;
  always_ff @(posedge clock)
  begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (read | write) & ~ack;
  end

  // Register select shared by read and write merge; unmapped reads zero
  always_comb
  begin
    case (address)
      `QQS_MODE_OFS: curVal = {30'h0, mode};
      `QQS_WEIGHT_OFS: curVal = weights;
      `QQS_MAP_OFS: curVal = {16'h0, prioMap};
      `QQS_PORTPRI_OFS: curVal = {{(32-PPW){1'b0}}, portPrio};
      `QQS_STATUS_OFS: curVal = status;
      default: curVal = 32'h0;
    endcase
  end
  assign merged = qqsMerge(curVal, writedata, byteenable);

  always_ff @(posedge clock)
  begin
    if (rst)
      readdata <= 32'h0;
    else if (read & ~ack)
      readdata <= curVal;
  end

  // Writes land at the edge where waitrequest is low
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode <= qqs_pkg::qqs_mode_e'(`QQS_MODE_RST);
      weights <= `QQS_WEIGHT_RST;
      prioMap <= `QQS_MAP_RST;
      portPrio <= {NUM_PORTS{`QQS_PORTPRI_RST}};
    end
    else if (write & ack)
    begin
      if (address == `QQS_MODE_OFS)
        mode <= qqs_pkg::qqs_mode_e'(merged[1:0]);
      if (address == `QQS_WEIGHT_OFS)
        weights <= merged;
      if (address == `QQS_MAP_OFS)
        prioMap <= merged[15:0];
      if (address == `QQS_PORTPRI_OFS)
        portPrio <= merged[PPW-1:0];
    end
  end
endmodule : qqs_cfg_slave
`default_nettype wire

// file: verilog/qqs_queue_sched.sv
// Four-queue QoS classifier and egress scheduler
`timescale 1ns/100ps
`default_nettype none
`include "qqs_regs.svh"
module qqs_queue_sched #(
  parameter int DATA_W = 16,
  parameter int QDEPTH = 8,
  parameter int NUM_PORTS = 8,
  parameter int PORT_W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic inValid,
  output logic inReady,
  input wire logic [DATA_W-1:0] inData,
  input wire logic inTagged,
  input wire logic [2:0] inPriority,
  input wire logic [PORT_W-1:0] inPort,
  output logic txValid,
  input wire logic txReady,
  output logic [DATA_W-1:0] txData,
  output logic [1:0] txQueue
);
  localparam int PW = $clog2(QDEPTH);
  localparam int CW = PW + 1;
  localparam int SW = $clog2(4 * QDEPTH) + 1;
  localparam logic [CW-1:0] FULL = CW'(QDEPTH);

  qqs_pkg::qqs_mode_e mode;
  logic [31:0] weights;
  logic [15:0] prioMap;
  logic [3*NUM_PORTS-1:0] portPrio;
  logic [31:0] status;
  logic [CW-1:0] cnt [4];
  logic [PW-1:0] wrPtr [4];
  logic [PW-1:0] rdPtr [4];
  logic [SW-1:0] stamp [4][QDEPTH];
  logic [SW-1:0] stampCnt;
  logic [SW-1:0] headAge [4];
  logic [3:0] nonEmpty;
  logic [3:0] eligible;
  logic [2:0] effPrio;
  qqs_pkg::qqs_queue_t inQueue;
  qqs_pkg::qqs_queue_t pickQ;
  qqs_pkg::qqs_queue_t wrrSel;
  qqs_pkg::qqs_queue_t pendQ;
  logic anyElig;
  logic issue;
  logic enq;
  logic rdPending;
  logic [7:0] wrrCredit;
  logic [7:0] credUse;
  logic [DATA_W-1:0] memRdData;
  logic fcfsOk;

  // Queue for a priority in the two-bit-per-level map
  function automatic qqs_pkg::qqs_queue_t mapLookup(input logic [15:0] map,
                                                    input logic [2:0] prio);
    return map[`QQS_MAP_FIELD_W*prio +: `QQS_MAP_FIELD_W];
  endfunction : mapLookup

  // Static priority of a port; ports beyond the table read as zero
  function automatic logic [2:0] portPrioOf(input logic [3*NUM_PORTS-1:0] pp,
                                            input logic [PORT_W-1:0] port);
    logic [2:0] r;
    r = 3'h0;
    if (int'(port) < NUM_PORTS)
      r = pp[`QQS_PORTPRI_FIELD_W*port +: `QQS_PORTPRI_FIELD_W];
    return r;
  endfunction : portPrioOf

  // Weight byte of one queue
  function automatic logic [7:0] weightOf(input logic [31:0] w,
                                          input qqs_pkg::qqs_queue_t q);
    return w[`QQS_WEIGHT_FIELD_W*q +: `QQS_WEIGHT_FIELD_W];
  endfunction : weightOf

  // Register slave holds mode, weights, map and port priorities
  qqs_cfg_slave #(
    .NUM_PORTS(NUM_PORTS)
  ) cfgSlave (
    .clock(clock),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .status(status),
    .mode(mode),
    .weights(weights),
    .prioMap(prioMap),
    .portPrio(portPrio)
  );

  // Occupancy of each queue, highest rank in the low byte
  assign status = {8'(cnt[3]), 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])};

  // Classification: tag priority, else the port's static priority
  assign effPrio = inTagged ? inPriority : portPrioOf(portPrio, inPort);
  assign inQueue = mapLookup(prioMap, effPrio);

  // Back-pressure only when the target queue is full
  assign inReady = cnt[inQueue] != FULL;
  assign enq = inValid & inReady;

  // Per-queue flags and age of each head packet
  always_comb
  begin
    for (int q = 0; q < 4; q++)
    begin
      nonEmpty[q] = cnt[q] != '0;
      eligible[q] = nonEmpty[q] && weightOf(weights, 2'(q)) != 8'h00;
      headAge[q] = stampCnt - stamp[q][rdPtr[q]];
    end
  end

  // Queue choice for the next departure
  always_comb
  begin
    qqs_pkg::qqs_queue_t idx;
    idx = 2'h0;
    pickQ = 2'h0;
    anyElig = 1'b0;
    unique case (mode)
      qqs_pkg::QQS_OFF, qqs_pkg::QQS_FCFS:
      begin
        // Oldest head across all queues keeps arrival order
        for (int q = 0; q < 4; q++)
        begin
          if (nonEmpty[q] && (!anyElig || headAge[q] > headAge[pickQ]))
          begin
            pickQ = 2'(q);
            anyElig = 1'b1;
          end
        end
      end
      qqs_pkg::QQS_STRICT:
      begin
        // Scan downward so the highest-ranked busy queue is kept last
        for (int q = 3; q >= 0; q--)
        begin
          if (nonEmpty[q])
          begin
            pickQ = 2'(q);
            anyElig = 1'b1;
          end
        end
      end
      qqs_pkg::QQS_WRR:
      begin
        // First eligible queue at or after the current turn; empty ones skipped
        for (int k = 3; k >= 0; k--)
        begin
          idx = wrrSel + 2'(k);
          if (eligible[idx])
          begin
            pickQ = idx;
            anyElig = 1'b1;
          end
        end
      end
    endcase
  end

  // One descriptor in flight keeps the output path simple
  assign issue = anyElig & ~rdPending & (~txValid | txReady);

  // Zero credit means the turn is fresh and takes the full weight
  assign credUse = (pickQ == wrrSel && wrrCredit != 8'h00) ? wrrCredit : weightOf(weights, pickQ);

  // Pointers and occupancy; pointer wrap needs a power-of-two depth
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int q = 0; q < 4; q++)
      begin
        cnt[q] <= '0;
        wrPtr[q] <= '0;
        rdPtr[q] <= '0;
      end
    end
    else
    begin
      for (int q = 0; q < 4; q++)
      begin
        if (enq && inQueue == 2'(q))
          wrPtr[q] <= wrPtr[q] + 1'b1;
        if (issue && pickQ == 2'(q))
          rdPtr[q] <= rdPtr[q] + 1'b1;
        cnt[q] <= cnt[q] + CW'(enq && inQueue == 2'(q)) - CW'(issue && pickQ == 2'(q));
      end
    end
  end

  // Arrival counter; width covers every packet that can be queued at once
  always_ff @(posedge clock)
  begin
    if (rst)
      stampCnt <= '0;
    else if (enq)
      stampCnt <= stampCnt + 1'b1;
  end

  // Arrival stamps beside each queued descriptor
  always_ff @(posedge clock)
  begin
    if (enq)
      stamp[inQueue][wrPtr[inQueue]] <= stampCnt;
  end

  qqs_desc_mem #(
    .WIDTH(DATA_W),
    .WORDS(4 * QDEPTH)
  ) descMem (
    .clock(clock),
    .rst(rst),
    .wrEn(enq),
    .wrAddr({inQueue, wrPtr[inQueue]}),
    .wrData(inData),
    .rdEn(issue),
    .rdAddr({pickQ, rdPtr[pickQ]}),
    .rdData(memRdData)
  );

  // Output register loads one cycle after the memory read
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdPending <= 1'b0;
      pendQ <= 2'h0;
      txValid <= 1'b0;
      txData <= '0;
      txQueue <= 2'h0;
    end
    else
    begin
      rdPending <= issue;
      if (issue)
        pendQ <= pickQ;
      if (rdPending)
      begin
        txValid <= 1'b1;
        txData <= memRdData;
        txQueue <= pendQ;
      end
      else if (txReady)
        txValid <= 1'b0;
    end
  end

  // Round robin turn and credit; cleared outside the mode so entry starts at highest
  always_ff @(posedge clock)
  begin
    if (rst || mode != qqs_pkg::QQS_WRR)
    begin
      wrrSel <= 2'h0;
      wrrCredit <= 8'h00;
    end
    else if (issue)
    begin
      if (credUse <= 8'h01)
      begin
        wrrSel <= pickQ + 2'h1;
        wrrCredit <= 8'h00;
      end
      else
      begin
        wrrSel <= pickQ;
        wrrCredit <= credUse - 8'h01;
      end
    end
  end

  // Helper: no busy queue holds an older head than the one picked
  always_comb
  begin
    fcfsOk = 1'b1;
    for (int q = 0; q < 4; q++)
      if (nonEmpty[q] && headAge[q] > headAge[pickQ])
        fcfsOk = 1'b0;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  queue_bound_a: assert property (
    cnt[0] <= FULL && cnt[1] <= FULL && cnt[2] <= FULL && cnt[3] <= FULL)
    else $error("Queue count above depth");

  depart_latency_a: assert property (
    issue |=> !issue ##1 (txValid && txQueue == $past(pickQ, 2)))
    else $error("Departure not presented two cycles after issue");

  fcfs_order_a: assert property (
    (issue && (mode == qqs_pkg::QQS_OFF || mode == qqs_pkg::QQS_FCFS)) |-> fcfsOk)
    else $error("Arrival order broken");

  strict_rank_a: assert property (
    (issue && mode == qqs_pkg::QQS_STRICT) |-> (nonEmpty & ((4'h1 << pickQ) - 4'h1)) == 4'h0)
    else $error("Lower queue served while higher busy");

  reset_mode_a: assert property (
    $fell(rst) |-> (mode == qqs_pkg::QQS_WRR && weights == `QQS_WEIGHT_RST))
    else $error("Reset mode or weights wrong");

  wrr_burst_a: assert property (
    (issue && mode == qqs_pkg::QQS_WRR && credUse > 8'h01)
    |=> (wrrSel == $past(pickQ) && wrrCredit == $past(credUse) - 8'h01))
    else $error("Weight credit not kept on queue");

  tag_map_a: assert property (
    (enq && inTagged) |-> inQueue == prioMap[2*inPriority +: 2])
    else $error("Tagged packet in wrong queue");

  map_write_a: assert property (
    (write && !waitrequest && address == `QQS_MAP_OFS && byteenable == 4'hF)
    |=> prioMap == 16'($past(writedata)))
    else $error("Map write not taken");

  map_reset_a: assert property (
    $fell(rst) |-> prioMap == `QQS_MAP_RST)
    else $error("Reset map wrong");

  untag_map_a: assert property (
    (enq && !inTagged) |-> inQueue == mapLookup(prioMap, portPrioOf(portPrio, inPort)))
    else $error("Untagged packet in wrong queue");

  wrr_skip_a: assert property (
    (issue && mode == qqs_pkg::QQS_WRR)
    |-> (eligible[pickQ] && (pickQ == wrrSel || !eligible[wrrSel])))
    else $error("Round robin did not skip correctly");

  wrr_wrap_a: assert property (
    (issue && mode == qqs_pkg::QQS_WRR && pickQ == 2'h3 && credUse <= 8'h01)
    |=> (wrrSel == 2'h0 && wrrCredit == 8'h00))
    else $error("Round robin did not wrap to highest");

  fcfs_seen_c: cover property (issue && mode == qqs_pkg::QQS_FCFS && nonEmpty == 4'hF);
  strict_low_c: cover property (issue && mode == qqs_pkg::QQS_STRICT && pickQ == 2'h3);
  wrr_wrap_c: cover property (issue && mode == qqs_pkg::QQS_WRR && pickQ == 2'h3
    && credUse == 8'h01);
  queue_full_c: cover property (inValid && !inReady);
endmodule : qqs_queue_sched
`default_nettype wire

// file: sim/qqs_egress_sink.sv
// Egress sink model that accepts descriptors promptly, slowly or not at all
`timescale 1ns/100ps
`default_nettype none
module qqs_egress_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [15:0] txData,
  input wire logic [1:0] txQueue,
  output logic txReady
);
  logic phase;
  int count;
  logic [1:0] gotQ [0:63];
  logic [15:0] gotD [0:63];
  // Slow mode accepts every second cycle to stretch the hold of the output
  assign txReady = !hold && (!slow || phase);
  // Log accepted descriptors in the order they left
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase <= 1'b0;
      count <= 0;
    end
    else
    begin
      phase <= !phase;
      if (txValid && txReady)
      begin
        gotQ[count[5:0]] <= txQueue;
        gotD[count[5:0]] <= txData;
        count <= count + 1;
      end
    end
  end
endmodule : qqs_egress_sink
`default_nettype wire

// file: sim/tb_qqs_queue_sched.sv
// Self-checking bench for the QoS classifier and egress scheduler
`timescale 1ns/100ps
`default_nettype none
`include "qqs_regs.svh"
module tb_qqs_queue_sched;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic inValid = 1'b0;
  logic inReady;
  logic [15:0] inData = 16'h0;
  logic inTagged = 1'b0;
  logic [2:0] inPriority = 3'h0;
  logic [2:0] inPort = 3'h0;
  logic txValid;
  logic txReady;
  logic [15:0] txData;
  logic [1:0] txQueue;
  logic hold = 1'b1;
  logic slow = 1'b0;
  logic [31:0] rdv;
  int badCount = 0;
  int numChecks = 0;
  // 200 MHz clock
  always #2.5 clock = !clock;
  qqs_queue_sched #(.QDEPTH(16)) i_qqs_queue_sched (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .inValid(inValid), .inReady(inReady), .inData(inData), .inTagged(inTagged),
    .inPriority(inPriority), .inPort(inPort), .txValid(txValid),
    .txReady(txReady), .txData(txData), .txQueue(txQueue));
  qqs_egress_sink i_qqs_egress_sink (.clock(clock), .rst(rst), .hold(hold),
    .slow(slow), .txValid(txValid), .txData(txData), .txQueue(txQueue),
    .txReady(txReady));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    if (badCount == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Avalon cycle; held until waitrequest is seen low, then released
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    // Waitrequest and read data taken at the rising edge that ends the wait
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      badCount++;
      $display("Error %0t: bus timeout", $time);
    end
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // Offer one descriptor until the block takes it
  task push(input logic tg, input logic [2:0] p, input logic [2:0] pt,
            input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    inValid <= 1'b1;
    inTagged <= tg;
    inPriority <= p;
    inPort <= pt;
    inData <= d;
    // Ready judged at the rising edge where the descriptor is taken
    do
    begin
      @(posedge clock);
      n++;
    end
    while (inReady !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      badCount++;
      $display("Error %0t: ingress refused too long", $time);
    end
    inValid <= 1'b0;
  endtask : push
  task waitCnt(input int n);
    int k;
    k = 0;
    while (i_qqs_egress_sink.count < n && k < 500)
    begin
      @(posedge clock);
      k++;
    end
    if (k >= 500)
    begin
      badCount++;
      $display("Error %0t: egress stalled", $time);
    end
  endtask : waitCnt
  // One packet through, queue and payload compared
  task cls(input logic tg, input logic [2:0] p, input logic [2:0] pt,
           input logic [1:0] q);
    int c;
    c = i_qqs_egress_sink.count;
    push(tg, p, pt, 16'(c + 16'h0100));
    waitCnt(c + 1);
    chk(32'(i_qqs_egress_sink.gotQ[c]), 32'(q));
    chk(32'(i_qqs_egress_sink.gotD[c]), 32'(c + 16'h0100));
  endtask : cls
  task t_reset;
    bus(1'b0, `QQS_MODE_OFS, 32'h0);
    chk(rdv, 32'h3);
    bus(1'b0, `QQS_WEIGHT_OFS, 32'h0);
    chk(rdv, 32'h01020408);
    bus(1'b0, `QQS_MAP_OFS, 32'h0);
    chk(rdv, 32'h000005AF);
    bus(1'b0, `QQS_PORTPRI_OFS, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(rdv, 32'h0);
  endtask : t_reset
  task t_classify;
    hold <= 1'b0;
    slow <= 1'b1;
    bus(1'b1, `QQS_MODE_OFS, 32'h1);
    for (int p = 0; p < 8; p++)
      cls(1'b1, 3'(p), 3'h0, 2'(3 - p / 2));
    // Port 2 given priority 6; tag priority ignored when untagged
    bus(1'b1, `QQS_PORTPRI_OFS, 32'h00000180);
    cls(1'b0, 3'h1, 3'h2, 2'h0);
    cls(1'b0, 3'h5, 3'h0, 2'h3);
    bus(1'b1, `QQS_MAP_OFS, 32'h000035AF);
    bus(1'b0, `QQS_MAP_OFS, 32'h0);
    chk(rdv, 32'h000035AF);
    cls(1'b0, 3'h1, 3'h2, 2'h3);
    cls(1'b1, 3'h6, 3'h0, 2'h3);
    bus(1'b1, `QQS_MAP_OFS, 32'h000005AF);
    slow <= 1'b0;
  endtask : t_classify
  // Fill queues under strict priority with egress stalled, then switch
  // mode and release; the first packet is already out and is skipped
  task t_order(input qqs_pkg::qqs_mode_e m, input int n,
               input logic [63:0] pq, input logic [63:0] eq);
    int c;
    c = i_qqs_egress_sink.count;
    @(posedge clock);
    hold <= 1'b1;
    bus(1'b1, `QQS_MODE_OFS, 32'h2);
    push(1'b1, 3'h0, 3'h0, 16'hFFFF);
    repeat (4) @(posedge clock);
    for (int i = 0; i < n; i++)
      push(1'b1, 3'(6 - 2 * pq[4*i +: 2]), 3'h0, 16'(i));
    bus(1'b1, `QQS_MODE_OFS, {30'h0, m});
    @(posedge clock);
    hold <= 1'b0;
    waitCnt(c + n + 1);
    for (int i = 0; i < n; i++)
      chk(32'(i_qqs_egress_sink.gotQ[c + 1 + i]), 32'(eq[4*i +: 2]));
  endtask : t_order
  // Lowest queue filled behind a held egress; one more offer must be refused
  task t_full;
    int c;
    c = i_qqs_egress_sink.count;
    @(posedge clock);
    hold <= 1'b1;
    for (int i = 0; i < 17; i++)
      push(1'b1, 3'h0, 3'h0, 16'(i));
    @(posedge clock);
    inValid <= 1'b1;
    @(posedge clock);
    chk(32'(inReady), 32'h0);
    inValid <= 1'b0;
    bus(1'b0, `QQS_STATUS_OFS, 32'h0);
    chk(rdv, 32'h10000000);
    hold <= 1'b0;
    waitCnt(c + 17);
    chk(32'(i_qqs_egress_sink.gotQ[c + 16]), 32'h3);
  endtask : t_full
  initial
  begin
    #400000;
    badCount++;
    $display("Error %0t: watchdog expired", $time);
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_classify();
    t_order(qqs_pkg::QQS_WRR, 11, 64'h11000000000, 64'h1100000000);
    bus(1'b1, `QQS_WEIGHT_OFS, 32'h01010102);
    t_order(qqs_pkg::QQS_WRR, 6, 64'h311000, 64'h103100);
    t_order(qqs_pkg::QQS_STRICT, 5, 64'h00213, 64'h32100);
    t_order(qqs_pkg::QQS_FCFS, 4, 64'h1203, 64'h1203);
    t_order(qqs_pkg::QQS_OFF, 4, 64'h0213, 64'h0213);
    t_full();
    summarize();
  end
endmodule : tb_qqs_queue_sched
`default_nettype wire
